// ### logic/sfc_config_regs.sv
// Configuration register bank of a serial ferroelectric memory: drive select,
// sleep-on-reset and register read latency, with volatile and nonvolatile copies.
// Assumes an SPI mode 0 master on selN/linkClk/mosi; single-line transfers only.
`timescale 1ns/1ps
`include "sfc_cfg.svh"

// Function
// - The drive select field in bits seven to five of register four sets output strength.
// - The drive select field resets to the 45 ohm code and software may rewrite it.
// - With powerdown_on_reset set and select high, hard reset completion enters deep sleep.
// - Deep sleep is left after the exit delay once a long select pulse or hard reset comes.
// - A software reset ignores powerdown_on_reset and always lands in standby.
// - Register five is written only by the any-address write and read by two commands.
// - Register five is written at 0x000006 nonvolatile and 0x070006 volatile; a read at either address returns the volatile copy.
// - The latency code in bits seven and six inserts zero to three dummy clocks on reads.
// - That latency applies to every variable-latency register read command.
// - Both copies of register five reset to zero and bits five to zero read zero.
// - Each instruction is taken into an 8-bit register, framed by a falling select.
// - Register four lives at 0x000005 nonvolatile and 0x070005 volatile.
module sfc_config_regs #(
    parameter int EXIT_CYC = `SFC_EXIT_DELAY_CYC
) (
    // System clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Reset causes from the device core
    input  wire logic        hardResetReq,
    input  wire logic        softResetReq,
    // Serial link
    input  wire logic        linkClk,
    input  wire logic        selN,
    input  wire logic        mosi,
    output logic             miso,
    output logic             misoOe,
    // Configuration and power state
    output logic [2:0]       driveStrengthSel,
    output logic [1:0]       regLatency,
    output logic             deepSleep
);
    // ---------------- link domain ----------------
    sfc_pkg::sfc_frame_e frameState;
    logic [7:0]  instr;
    logic [23:0] addr;
    logic [7:0]  shiftIn;
    logic [7:0]  shiftOut;
    logic [4:0]  bitCnt;
    logic [1:0]  dummyCnt;
    logic        wrTog;
    logic [23:0] wrAddrL;
    logic [7:0]  wrDataL;
    logic [7:0]  cfg4Lnk1, cfg4Lnk2, cfg5Lnk1, cfg5Lnk2;
    logic [7:0]  cfg4Nv, cfg4Vol, cfg5Nv, cfg5Vol;

    // Bring settled register copies into the link domain
    always_ff @(posedge linkClk) begin
        cfg4Lnk1 <= cfg4Vol;
        cfg4Lnk2 <= cfg4Lnk1;
        cfg5Lnk1 <= cfg5Vol;
        cfg5Lnk2 <= cfg5Lnk1;
    end

    wire [7:0] nextShift = {shiftIn[6:0], mosi};
    wire       isAarRead = instr == `SFC_OP_AAR_READ;
    // Variable-latency read opcodes
    wire       isLatRead = (nextShift == `SFC_OP_STAT1_READ) ||
                           (nextShift == `SFC_OP_STAT2_READ) ||
                           (nextShift == `SFC_OP_CFG1_READ)  ||
                           (nextShift == `SFC_OP_CFG2_READ)  ||
                           (nextShift == `SFC_OP_CFG4_READ)  ||
                           (nextShift == `SFC_OP_CFG5_READ)  ||
                           (nextShift == `SFC_OP_UID_READ)   ||
                           (nextShift == `SFC_OP_ID2_READ)   ||
                           (nextShift == `SFC_OP_SN_READ);
    wire [23:0] nextAddr = {addr[22:0], mosi};
    // Read mux for both the dedicated and any-address reads
    wire       aIs4 = (nextAddr == `SFC_ADDR_CFG4_NV) || (nextAddr == `SFC_ADDR_CFG4_VOL);
    wire       aIs5 = (nextAddr == `SFC_ADDR_CFG5_NV) || (nextAddr == `SFC_ADDR_CFG5_VOL);
    wire [7:0] aarData = aIs4 ? cfg4Lnk2 : (aIs5 ? cfg5Lnk2 : 8'h00);
    wire [7:0] opData = (nextShift == `SFC_OP_CFG4_READ) ? cfg4Lnk2 :
                        (nextShift == `SFC_OP_CFG5_READ) ? cfg5Lnk2 : 8'h00;
    wire [1:0] latNow = cfg5Lnk2[`SFC_LAT_MSB:`SFC_LAT_LSB];

    // Frame decoder; a high select holds it at the opcode phase
    always_ff @(posedge linkClk or posedge selN) begin
        if (selN) begin
            frameState <= sfc_pkg::SFC_FR_OP;
            bitCnt     <= 5'h00;
            shiftIn    <= 8'h00;
            instr      <= 8'h00;
            addr       <= 24'h000000;
            dummyCnt   <= 2'h0;
        end else begin
            case (frameState)
                sfc_pkg::SFC_FR_OP: begin
                    shiftIn <= nextShift;
                    bitCnt  <= bitCnt + 5'h01;
                    if (bitCnt == 5'h07) begin
                        instr  <= nextShift;
                        bitCnt <= 5'h00;
                        dummyCnt <= latNow;
                        if (nextShift == `SFC_OP_AAR_WRITE || nextShift == `SFC_OP_AAR_READ) begin
                            frameState <= sfc_pkg::SFC_FR_ADDR;
                        end else if (isLatRead) begin
                            frameState <= (latNow == 2'h0) ? sfc_pkg::SFC_FR_RDATA
                                                           : sfc_pkg::SFC_FR_DUMMY;
                        end else begin
                            frameState <= sfc_pkg::SFC_FR_IGNORE;
                        end
                    end
                end
                sfc_pkg::SFC_FR_ADDR: begin
                    addr   <= nextAddr;
                    bitCnt <= bitCnt + 5'h01;
                    if (bitCnt == 5'h17) begin
                        bitCnt <= 5'h00;
                        if (!isAarRead) begin
                            frameState <= sfc_pkg::SFC_FR_WDATA;
                        end else begin
                            frameState <= (latNow == 2'h0) ? sfc_pkg::SFC_FR_RDATA
                                                           : sfc_pkg::SFC_FR_DUMMY;
                        end
                    end
                end
                sfc_pkg::SFC_FR_WDATA: begin
                    shiftIn <= nextShift;
                    bitCnt  <= bitCnt + 5'h01;
                    if (bitCnt == 5'h07) begin
                        frameState <= sfc_pkg::SFC_FR_IGNORE;
                    end
                end
                sfc_pkg::SFC_FR_DUMMY: begin
                    // Dummy clocks counted down
                    dummyCnt <= dummyCnt - 2'h1;
                    if (dummyCnt == 2'h1) begin
                        frameState <= sfc_pkg::SFC_FR_RDATA;
                    end
                end
                default: begin
                    frameState <= frameState;
                end
            endcase
        end
    end

    // Write capture, handed across by toggle
    // Toggle cleared by system reset so the crossing starts from a known level
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            wrAddrL <= 24'h000000;
            wrDataL <= 8'h00;
            wrTog   <= 1'b0;
        end else if (frameState == sfc_pkg::SFC_FR_WDATA && bitCnt == 5'h07 && !selN) begin
            wrAddrL <= addr;
            wrDataL <= nextShift;
            wrTog   <= ~wrTog;
        end
    end

    // Output shifter on the falling edge; data loaded when the read phase opens
    logic readLoad;
    assign readLoad = (frameState == sfc_pkg::SFC_FR_OP && bitCnt == 5'h07 && isLatRead) ||
                      (frameState == sfc_pkg::SFC_FR_ADDR && bitCnt == 5'h17 && isAarRead);
    logic [7:0] loadVal;
    always_ff @(posedge linkClk) begin
        if (readLoad) begin
            loadVal <= (frameState == sfc_pkg::SFC_FR_ADDR) ? aarData : opData;
        end
    end
    always_ff @(negedge linkClk or posedge selN) begin
        if (selN) begin
            shiftOut <= 8'h00;
            miso     <= 1'b0;
            misoOe   <= 1'b0;
        end else if (frameState == sfc_pkg::SFC_FR_RDATA) begin
            if (!misoOe) begin
                miso     <= loadVal[7];
                shiftOut <= {loadVal[6:0], 1'b0};
            end else begin
                miso     <= shiftOut[7];
                shiftOut <= {shiftOut[6:0], 1'b0};
            end
            misoOe <= 1'b1;
        end
    end

    // ---------------- system domain ----------------
    logic [2:0] wrTogSync;
    logic [1:0] selSync;
    logic [7:0] wrAddrByteSel;
    logic       cfgWrite;
    sfc_pkg::sfc_pwr_e pwrState;
    logic [15:0] pulseCnt;
    logic [15:0] exitCnt;
    logic        selHighD;

    // Two-stage synchronisers for the toggle and the select pin
    always_ff @(posedge ref_clk) begin
        wrTogSync <= {wrTogSync[1:0], wrTog};
        selSync   <= {selSync[0], selN};
    end
    assign cfgWrite = wrTogSync[2] ^ wrTogSync[1];

    // Write decode; held write words are stable while the toggle crosses
    wire w4Nv  = cfgWrite && wrAddrL == `SFC_ADDR_CFG4_NV;
    wire w4Vol = cfgWrite && wrAddrL == `SFC_ADDR_CFG4_VOL;
    wire w5Nv  = cfgWrite && wrAddrL == `SFC_ADDR_CFG5_NV;
    wire w5Vol = cfgWrite && wrAddrL == `SFC_ADDR_CFG5_VOL;
    // Reserved bits forced; bit three held at one as the host is told to
    wire [7:0] w4Val = (wrDataL & `SFC_CFG4_KEEP_MASK) | `SFC_CFG4_ONE_MASK;
    wire [7:0] w5Val = wrDataL & `SFC_CFG5_KEEP_MASK;
    // Reserved drive code keeps the old field; a nonvolatile write loads the volatile field from the nonvolatile one
    wire       drvBad = w4Val[`SFC_DRV_MSB:`SFC_DRV_LSB] == `SFC_DRV_BAD;
    wire [7:0] w4Keep = {cfg4Vol[7:5], w4Val[4:0]};
    wire [7:0] w4KeepNv = {cfg4Nv[7:5], w4Val[4:0]};

    // Register copies; hard and soft reset requests restore volatile from nonvolatile
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg4Nv  <= `SFC_CFG4_RESET;
            cfg4Vol <= `SFC_CFG4_RESET;
            cfg5Nv  <= `SFC_CFG5_RESET;
            cfg5Vol <= `SFC_CFG5_RESET;
        end else if (hardResetReq || softResetReq) begin
            cfg4Vol <= cfg4Nv;
            cfg5Vol <= cfg5Nv;
        end else begin
            if (w4Nv) begin
                cfg4Nv  <= drvBad ? w4KeepNv : w4Val;
                cfg4Vol <= drvBad ? w4KeepNv : w4Val;
            end
            if (w4Vol) begin
                cfg4Vol <= drvBad ? w4Keep : w4Val;
            end
            if (w5Nv) begin
                cfg5Nv  <= w5Val;
                cfg5Vol <= w5Val;
            end
            if (w5Vol) begin
                cfg5Vol <= w5Val;
            end
        end
    end

    // Sleep control: reset entry, select-pulse wake, timed exit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pwrState <= sfc_pkg::SFC_PWR_STANDBY;
            pulseCnt <= 16'h0000;
            exitCnt  <= 16'h0000;
        end else if (softResetReq) begin
            pwrState <= sfc_pkg::SFC_PWR_STANDBY;
        end else if (hardResetReq) begin
            if (pwrState == sfc_pkg::SFC_PWR_SLEEP) begin
                pwrState <= sfc_pkg::SFC_PWR_EXIT;
                exitCnt  <= 16'h0000;
            end else if (cfg4Nv[`SFC_PDR_BIT] && selSync[1]) begin
                pwrState <= sfc_pkg::SFC_PWR_SLEEP;
            end
        end else begin
            case (pwrState)
                sfc_pkg::SFC_PWR_SLEEP: begin
                    pulseCnt <= selSync[1] ? 16'h0000 : pulseCnt + 16'h0001;
                    if (selSync[1] && pulseCnt >= 16'(`SFC_SEL_PULSE_CYC)) begin
                        pwrState <= sfc_pkg::SFC_PWR_EXIT;
                        exitCnt  <= 16'h0000;
                    end
                end
                sfc_pkg::SFC_PWR_EXIT: begin
                    exitCnt <= exitCnt + 16'h0001;
                    if (exitCnt == 16'(EXIT_CYC - 1)) begin
                        pwrState <= sfc_pkg::SFC_PWR_STANDBY;
                    end
                end
                default: begin
                    pulseCnt <= 16'h0000;
                end
            endcase
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            driveStrengthSel <= 3'h0;
            regLatency       <= 2'h0;
            deepSleep        <= 1'b0;
        end else begin
            driveStrengthSel <= cfg4Vol[`SFC_DRV_MSB:`SFC_DRV_LSB];
            regLatency       <= cfg5Vol[`SFC_LAT_MSB:`SFC_LAT_LSB];
            deepSleep        <= pwrState != sfc_pkg::SFC_PWR_STANDBY;
        end
    end

    // Checks
    a_soft_reset_standby: assert property (@(posedge ref_clk) disable iff (!rst_n)
        softResetReq |=> pwrState == sfc_pkg::SFC_PWR_STANDBY)
        else $error("soft reset did not give standby");
    a_drive_never_bad: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg4Vol[7:5] != 3'h7)
        else $error("reserved drive code stored");
    a_cfg5_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg5Vol[5:0] == 6'h00 && cfg5Nv[5:0] == 6'h00)
        else $error("reserved latency bits set");
    a_cfg5_vol_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        w5Vol && !hardResetReq && !softResetReq |=> cfg5Vol == $past(w5Val))
        else $error("volatile latency write lost");
    a_cfg4_vol_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        w4Vol && !drvBad && !hardResetReq && !softResetReq |=> cfg4Vol == $past(w4Val))
        else $error("volatile drive write lost");
    a_drive_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 driveStrengthSel == $past(cfg4Vol[7:5]))
        else $error("drive output stale");
    a_sleep_on_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hardResetReq && !softResetReq && pwrState == sfc_pkg::SFC_PWR_STANDBY
        && cfg4Nv[2] && selSync[1] |=> ##1 deepSleep)
        else $error("no sleep after reset");
    a_latency_follows: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 regLatency == $past(cfg5Vol[7:6]))
        else $error("latency output stale");

    // Wake steps: a long select pulse, then the timed exit back to standby
    sequence s_long_select;
        pwrState == sfc_pkg::SFC_PWR_SLEEP && selSync[1] && !hardResetReq && !softResetReq
        && pulseCnt >= 16'(`SFC_SEL_PULSE_CYC);
    endsequence
    sequence s_exit_end;
        pwrState == sfc_pkg::SFC_PWR_EXIT && exitCnt == 16'(EXIT_CYC - 1)
        && !hardResetReq && !softResetReq;
    endsequence
    a_pulse_wake: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_long_select |=> pwrState == sfc_pkg::SFC_PWR_EXIT)
        else $error("long select pulse did not start exit");
    a_exit_standby: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_exit_end |=> pwrState == sfc_pkg::SFC_PWR_STANDBY ##1 !deepSleep)
        else $error("exit delay did not end in standby");
    a_hard_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hardResetReq && !softResetReq |=> cfg4Vol == $past(cfg4Nv) && cfg5Vol == $past(cfg5Nv))
        else $error("volatile copies not reloaded");
    a_dummy_count: assert property (@(posedge linkClk) disable iff (selN)
        frameState == sfc_pkg::SFC_FR_DUMMY && dummyCnt == 2'h1 |=>
        frameState == sfc_pkg::SFC_FR_RDATA)
        else $error("dummy clocks not ended");
endmodule : sfc_config_regs

// ### pkg/sfc_cfg.svh
// Constants for the serial memory configuration register block.
// Assumes inclusion by the design module and the bench only.
`ifndef SFC_CFG_SVH
`define SFC_CFG_SVH
`define SFC_ADDR_CFG4_NV     24'h000005
`define SFC_ADDR_CFG4_VOL    24'h070005
`define SFC_ADDR_CFG5_NV     24'h000006
`define SFC_ADDR_CFG5_VOL    24'h070006
`define SFC_OP_AAR_WRITE     8'h71
`define SFC_OP_AAR_READ      8'h65
`define SFC_OP_STAT1_READ    8'h05
`define SFC_OP_STAT2_READ    8'h07
`define SFC_OP_CFG1_READ     8'h35
`define SFC_OP_CFG2_READ     8'h3f
`define SFC_OP_CFG4_READ     8'h45
`define SFC_OP_CFG5_READ     8'h5e
`define SFC_OP_UID_READ      8'h4c
`define SFC_OP_ID2_READ      8'h9f
`define SFC_OP_SN_READ       8'hc3
`define SFC_CFG4_RESET       8'h08
`define SFC_CFG5_RESET       8'h00
`define SFC_CFG4_KEEP_MASK   8'he4
`define SFC_CFG4_ONE_MASK    8'h08
`define SFC_CFG5_KEEP_MASK   8'hc0
`define SFC_DRV_MSB          7
`define SFC_DRV_LSB          5
`define SFC_PDR_BIT          2
`define SFC_LAT_MSB          7
`define SFC_LAT_LSB          6
`define SFC_DRV_BAD          3'h7
`define SFC_SEL_PULSE_NS     200
`define SFC_EXIT_DELAY_NS    3000
`define SFC_CLK_MHZ          50
`define SFC_SEL_PULSE_CYC    ((`SFC_SEL_PULSE_NS * `SFC_CLK_MHZ + 999) / 1000)
`define SFC_EXIT_DELAY_CYC   ((`SFC_EXIT_DELAY_NS * `SFC_CLK_MHZ + 999) / 1000)
`endif

// ### pkg/sfc_pkg.sv
// Types for the serial memory configuration register block.
// Assumes the constants header sits beside it.
package sfc_pkg;
    // Power state of the device
    typedef enum logic [1:0] {SFC_PWR_STANDBY, SFC_PWR_SLEEP, SFC_PWR_EXIT} sfc_pwr_e;
    // Serial frame state
    typedef enum logic [2:0] {
        SFC_FR_OP, SFC_FR_ADDR, SFC_FR_WDATA, SFC_FR_DUMMY, SFC_FR_RDATA, SFC_FR_IGNORE
    } sfc_frame_e;
    // Configuration seen by the core
    typedef struct packed {
        logic [2:0] driveSelect;
        logic       powerdownOnReset;
        logic [1:0] registerLatencyCode;
    } sfc_cfg_s;
    // Reset causes
    typedef struct packed {
        logic hardReset;
        logic softReset;
    } sfc_rst_s;
endpackage : sfc_pkg

// ### bench/sfc_spi_host.sv
// SPI mode 0 master model for the configuration register bank.
// Assumes single-line frames; link clock stands low between frames.
`timescale 1ns/1ps
module sfc_spi_host (
    // Serial link
    output logic      linkClk,
    output logic      selN,
    output logic      mosi,
    input  wire logic miso,
    input  wire logic misoOe
);
    // Idle levels: select high, clock low
    initial begin
        linkClk = 1'b0;
        selN    = 1'b0;
        mosi    = 1'b0;
        // Rising select clears the link logic before the first frame
        #1 selN = 1'b1;
    end

    // One command per select low; an 80 ns clock keeps well under 50 MHz
    task automatic xfer(input logic [39:0] v, input int nOut, input int nDummy,
                        input int nIn, output logic [7:0] rd);
        int total;
        total = nOut + nDummy + nIn;
        rd    = 8'h00;
        selN  = 1'b0;
        for (int i = 0; i < total; i++) begin
            // Bits beyond the command toggle so a stale level is never read
            mosi = (i < nOut) ? v[39 - i] : ~mosi;
            #40 linkClk = 1'b1;
            if (i >= nOut + nDummy) begin
                rd[total - 1 - i] = misoOe ? miso : 1'bx;
            end
            #40 linkClk = 1'b0;
        end
        #40 selN = 1'b1;
        mosi = ~mosi;
        // Gap lets a write settle before the next frame
        #200;
    endtask : xfer

    // Select pulse alone, clock and data left idle
    task automatic pulse(input int ns);
        selN = 1'b0;
        #(ns) selN = 1'b1;
    endtask : pulse
endmodule : sfc_spi_host

// ### bench/tb_top.sv
// Self-checking bench for the configuration register bank over its link.
// Assumes sfc_spi_host as link master and a shortened exit delay.
`timescale 1ns/1ps
`include "sfc_cfg.svh"
module tb_top;
    localparam int EXIT = 8;
    logic       ref_clk      = 1'b0;
    logic       rst_n        = 1'b0;
    logic       hardResetReq = 1'b0;
    logic       softResetReq = 1'b0;
    logic       linkClk;
    logic       selN;
    logic       mosi;
    logic       miso;
    logic       misoOe;
    logic [2:0] driveStrengthSel;
    logic [1:0] regLatency;
    logic       deepSleep;
    logic [7:0] rd;
    logic [7:0] ops [7] = '{8'h05, 8'h07, 8'h35, 8'h3f, 8'h4c, 8'h9f, 8'hc3};
    int         lat         = 0;
    int         n           = 0;
    int         err_total   = 0;
    int         check_count = 0;
    int         cycles      = 0;

    sfc_config_regs #(.EXIT_CYC(EXIT)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .hardResetReq(hardResetReq),
        .softResetReq(softResetReq), .linkClk(linkClk), .selN(selN), .mosi(mosi),
        .miso(miso), .misoOe(misoOe), .driveStrengthSel(driveStrengthSel),
        .regLatency(regLatency), .deepSleep(deepSleep));
    sfc_spi_host u_host (
        .linkClk(linkClk), .selN(selN), .mosi(mosi), .miso(miso), .misoOe(misoOe));

    // 50 MHz system clock
    always #10 ref_clk = ~ref_clk;

    // Hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
        #2;
    endtask : cyc

    task automatic check_read(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t read %h expected %h", $time, got, exp);
        end
    endtask : check_read

    task automatic check_port(input logic [2:0] got, input logic [2:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t port %h expected %h", $time, got, exp);
        end
    endtask : check_port

    // Writes go only through the any-address write
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        u_host.xfer({`SFC_OP_AAR_WRITE, a, d}, 40, 0, 0, rd);
    endtask : wr

    task automatic rd_any(input logic [23:0] a);
        u_host.xfer({`SFC_OP_AAR_READ, a, 8'h00}, 32, lat, 8, rd);
    endtask : rd_any

    task automatic rd_op(input logic [7:0] op);
        u_host.xfer({op, 32'h0}, 8, lat, 8, rd);
    endtask : rd_op

    task automatic finish_test();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // Main sequence
    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(4);
        check_port(driveStrengthSel, 3'h0);
        check_port({1'b0, regLatency}, 3'h0);
        check_port({2'b00, deepSleep}, 3'h0);
        rd_op(`SFC_OP_CFG4_READ);
        check_read(rd, `SFC_CFG4_RESET);
        rd_op(`SFC_OP_CFG5_READ);
        check_read(rd, 8'h00);
        // Every documented drive code, bit three kept at one
        for (int c = 0; c < 7; c++) begin
            wr(`SFC_ADDR_CFG4_NV, {c[2:0], 5'h08});
            check_port(driveStrengthSel, c[2:0]);
        end
        wr(`SFC_ADDR_CFG4_NV, 8'hf8);
        check_port(driveStrengthSel, 3'h6);
        rd_any(`SFC_ADDR_CFG4_NV);
        check_read(rd, 8'hc8);
        rd_any(`SFC_ADDR_CFG4_VOL);
        check_read(rd, 8'hc8);
        // Each latency code, reserved bits written as ones
        for (int l = 0; l < 4; l++) begin
            wr(`SFC_ADDR_CFG5_VOL, {l[1:0], 6'h3f});
            lat = l;
            check_port({1'b0, regLatency}, {1'b0, l[1:0]});
            rd_op(`SFC_OP_CFG5_READ);
            check_read(rd, {l[1:0], 6'h00});
            rd_any(`SFC_ADDR_CFG5_VOL);
            check_read(rd, {l[1:0], 6'h00});
            rd_op(`SFC_OP_CFG4_READ);
            check_read(rd, 8'hc8);
        end
        // Other latency reads must drive data after the dummies
        foreach (ops[i]) begin
            rd_op(ops[i]);
            check_read(rd, 8'h00);
        end
        wr(24'h000007, 8'h00);
        check_port({1'b0, regLatency}, 3'h3);
        wr(`SFC_ADDR_CFG5_NV, 8'h40);
        lat = 1;
        check_port({1'b0, regLatency}, 3'h1);
        rd_any(`SFC_ADDR_CFG5_NV);
        check_read(rd, 8'h40);
        // Sleep on hard reset, volatile copy reloaded
        wr(`SFC_ADDR_CFG4_NV, 8'hac);
        wr(`SFC_ADDR_CFG4_VOL, 8'h48);
        check_port(driveStrengthSel, 3'h2);
        cyc(1);
        hardResetReq = 1'b1;
        cyc(1);
        hardResetReq = 1'b0;
        cyc(3);
        check_port({2'b00, deepSleep}, 3'h1);
        check_port(driveStrengthSel, 3'h5);
        // Short pulse keeps sleep, long pulse wakes after the exit delay
        u_host.pulse(60);
        cyc(EXIT + 6);
        check_port({2'b00, deepSleep}, 3'h1);
        u_host.pulse(300);
        cyc(4);
        check_port({2'b00, deepSleep}, 3'h1);
        n = 0;
        while (deepSleep !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        check_port({2'b00, n <= EXIT}, 3'h1);
        // Software reset never sleeps
        wr(`SFC_ADDR_CFG4_VOL, 8'h48);
        cyc(1);
        softResetReq = 1'b1;
        cyc(1);
        softResetReq = 1'b0;
        cyc(EXIT + 4);
        check_port({2'b00, deepSleep}, 3'h0);
        check_port(driveStrengthSel, 3'h5);
        finish_test();
    end
endmodule : tb_top
